// ===== lf_wakeup_front_end_control.v
`timescale 1ns/100ps
`include "lf_front_end_regs.vh"
module lf_wakeup_front_end_control #(
	parameter AGC_PERIODS = `AGC_SETTLE_PERIODS,
	parameter SLOT_TICKS = `SLOT_RTC_TICKS,
	parameter MISS_HALF = `MISS_HALF_SYMBOLS
) (
	input wire mclk,
	input wire rst,
	input wire clkEn,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Analog side
	input wire rtcTick,
	input wire carrierTick,
	input wire halfSymTick,
	input wire [2:0] carrierRaw,
	input wire [2:0] gainDownReq,
	input wire [2:0] gainUpReq,
	input wire wakeInternal,
	output reg [2:0] chanPowerOn,
	output reg [1:0] detTolerance,
	output reg [14:0] gainSetting,
	output reg [2:0] agcActive,
	output reg [1:0] selChannel,
	output reg selValid,
	output reg [3:0] startGainRed,
	output reg damperOn,
	output reg [1:0] damperShunt,
	output reg [2:0] envRate,
	output reg [2:0] slicerTime,
	output reg slicerSymm,
	output reg slicerThr40,
	output reg slicerAbs,
	output reg slicerAbsLow,
	output reg listenMode
);
	// ****************************************
	// Configuration registers
	// ****************************************
	reg [7:0] cfgA_ff; // Enables, AGC mode, damper, abs threshold
	reg [7:0] cfgB_ff; // Tolerance, abs threshold lowering
	reg [7:0] cfgC_ff; // Slicer and envelope detector
	reg [7:0] cfgD_ff; // Damper shunt, starting gain
	reg [1:0] tolEff_ff; // Last legal tolerance code
	reg [3:0] gredEff_ff; // Last legal gain reduction code
	reg wakeClrPulse; // One-cycle wake clear command
	reg strRestartPulse; // One-cycle strength restart command
	reg wakeLatched_ff; // Wake condition held until cleared
	// ****************************************
	// Bus handshake state
	// ****************************************
	reg awHeld_ff;
	reg wHeld_ff;
	reg [7:0] awAddr_ff;
	reg [31:0] wData_ff;
	reg [3:0] wStrb_ff;
	wire doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
	// Accept each channel once; hold until the response is sent
	assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	// Strength per channel, read-only
	wire [4:0] str0 = gainSetting[4:0];
	wire [4:0] str1 = gainSetting[9:5];
	wire [4:0] str2 = gainSetting[14:10];
	// ****************************************
	// Write channel and register storage
	// ****************************************
	// Address and data may come in either order
	always @(posedge mclk) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			cfgA_ff <= `RST_CFG_A;
			cfgB_ff <= `RST_CFG_B;
			cfgC_ff <= `RST_CFG_C;
			cfgD_ff <= `RST_CFG_D;
			wakeClrPulse <= 1'b0;
			strRestartPulse <= 1'b0;
		end else if (clkEn) begin
			wakeClrPulse <= 1'b0;
			strRestartPulse <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				// Only lane 0 carries register bits
				case ({awAddr_ff[7:2], 2'b00})
					`OFF_CFG_A: if (wStrb_ff[0]) cfgA_ff <= wData_ff[7:0];
					`OFF_CFG_B: if (wStrb_ff[0]) cfgB_ff <= wData_ff[7:0];
					`OFF_CFG_C: if (wStrb_ff[0]) cfgC_ff <= wData_ff[7:0];
					`OFF_CFG_D: if (wStrb_ff[0]) cfgD_ff <= wData_ff[7:0];
					`OFF_CTRL: begin
						// Command bits self-clear; nothing is stored
						wakeClrPulse <= wStrb_ff[0] & wData_ff[`CTRL_CLR_WAKE];
						strRestartPulse <= wStrb_ff[0] & wData_ff[`CTRL_STR_RESTART];
					end
					`OFF_STRENGTH_1, `OFF_STRENGTH_2, `OFF_STRENGTH_3, `OFF_STATUS: s_axi_bresp <= 2'b10;
					default: s_axi_bresp <= 2'b11;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ****************************************
	// Read channel
	// ****************************************
	// Data registered; answer one cycle after address
	always @(posedge mclk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (clkEn) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case ({s_axi_araddr[7:2], 2'b00})
					`OFF_CFG_A: s_axi_rdata <= {24'h000000, cfgA_ff};
					`OFF_CFG_B: s_axi_rdata <= {24'h000000, cfgB_ff};
					`OFF_CFG_C: s_axi_rdata <= {24'h000000, cfgC_ff};
					`OFF_CFG_D: s_axi_rdata <= {24'h000000, cfgD_ff};
					`OFF_CTRL: s_axi_rdata <= 32'h00000000;
					`OFF_STRENGTH_1: s_axi_rdata <= {27'h0000000, str0};
					`OFF_STRENGTH_2: s_axi_rdata <= {27'h0000000, str1};
					`OFF_STRENGTH_3: s_axi_rdata <= {27'h0000000, str2};
					`OFF_STATUS: s_axi_rdata <= {24'h000000, wakeLatched_ff, selValid, selChannel, 1'b0, agcActive};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b11;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ****************************************
	// Legal-code filters
	// ****************************************
	// Reserved codes would confuse the analog trim, so keep the last legal one
	always @(posedge mclk) begin
		if (rst) begin
			tolEff_ff <= 2'b00;
			gredEff_ff <= 4'h0;
		end else if (clkEn) begin
			if (cfgB_ff[`B_TOL_HI:`B_TOL_LO] != 2'b11)
				tolEff_ff <= cfgB_ff[`B_TOL_HI:`B_TOL_LO];
			if (cfgD_ff[3:2] != 2'b00 || cfgD_ff[3:0] == 4'h0)
				gredEff_ff <= {cfgD_ff[3:1], 1'b0};
		end
	end
	// ****************************************
	// Wake condition, slot timer, channel pick
	// ****************************************
	reg [2:0] woke_ff; // Channels that reached wake-up
	reg [7:0] slotCnt_ff; // RTC ticks since first wake
	reg slotOpen_ff; // Within the selection/AGC time slot
	wire [2:0] carrierEn = carrierRaw & cfgA_ff[2:0];
	always @(posedge mclk) begin
		if (rst) begin
			wakeLatched_ff <= 1'b0;
			listenMode <= 1'b1;
			woke_ff <= 3'b000;
			slotCnt_ff <= 8'h00;
			slotOpen_ff <= 1'b0;
			selChannel <= 2'b00;
			selValid <= 1'b0;
		end else if (clkEn) begin
			if (wakeClrPulse) begin
				// Return to listening; a same-cycle wake is taken next cycle
				wakeLatched_ff <= 1'b0;
				listenMode <= 1'b1;
				woke_ff <= 3'b000;
				selValid <= 1'b0;
				slotOpen_ff <= 1'b0;
			end else begin
				if (wakeInternal && carrierEn != 3'b000) begin
					wakeLatched_ff <= 1'b1;
					listenMode <= 1'b0;
				end
				if (!selValid && carrierEn != 3'b000) begin
					// First channel wins at once
					selValid <= 1'b1;
					slotOpen_ff <= 1'b1;
					slotCnt_ff <= 8'h00;
					woke_ff <= carrierEn;
					selChannel <= carrierEn[0] ? 2'd0 : (carrierEn[1] ? 2'd1 : 2'd2);
				end else if (slotOpen_ff) begin
					woke_ff <= woke_ff | carrierEn;
					if (rtcTick) begin
						slotCnt_ff <= slotCnt_ff + 8'h01;
						if (slotCnt_ff + 8'h01 >= SLOT_TICKS[7:0])
							slotOpen_ff <= 1'b0;
					end
					// Later wakers in the slot: strongest wins
					if (woke_ff[0] && str0 >= str1 && str0 >= str2) selChannel <= 2'd0;
					else if (woke_ff[1] && str1 >= str2) selChannel <= 2'd1;
					else if (woke_ff[2]) selChannel <= 2'd2;
				end
			end
		end
	end
	// ****************************************
	// Per-channel gain control
	// ****************************************
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : agcChan
			reg [4:0] gain_ff; // Gain code, also the strength
			reg [5:0] settle_ff; // Carrier periods since start
			reg [1:0] miss_ff; // Half-symbols without carrier
			reg run_ff; // Gain control running
			wire frozen = cfgA_ff[`A_TIME_LIM] && selValid && !slotOpen_ff;
			always @(posedge mclk) begin
				if (rst) begin
					gain_ff <= 5'h00;
					settle_ff <= 6'h00;
					miss_ff <= 2'b00;
					run_ff <= 1'b0;
				end else if (clkEn) begin
					if (wakeClrPulse || strRestartPulse || !cfgA_ff[ch]) begin
						// Strength cleared; wake state untouched by restart
						gain_ff <= 5'h00;
						run_ff <= 1'b0;
						miss_ff <= 2'b00;
					end else if (!run_ff) begin
						if (carrierEn[ch]) begin
							// Start at maximum less the chosen reduction
							run_ff <= 1'b1;
							gain_ff <= `GAIN_MAX - {1'b0, gredEff_ff};
							settle_ff <= 6'h00;
						end
					end else begin
						if (halfSymTick) begin
							if (carrierEn[ch]) miss_ff <= 2'b00;
							else if (miss_ff + 2'b01 >= MISS_HALF[1:0]) run_ff <= 1'b0;
							else miss_ff <= miss_ff + 2'b01;
						end
						if (halfSymTick && !carrierEn[ch] && miss_ff + 2'b01 >= MISS_HALF[1:0])
							gain_ff <= 5'h00;
						else if (carrierTick && !frozen) begin
							// Steps inside the settling window; after it, down steps go on in both modes
							if (settle_ff < AGC_PERIODS[5:0]) begin
								settle_ff <= settle_ff + 6'h01;
								if (gainDownReq[ch] && gain_ff != 5'h00) gain_ff <= gain_ff - 5'h01;
								else if (cfgA_ff[`A_AGC_UPDN] && gainUpReq[ch] && gain_ff != `GAIN_MAX)
									gain_ff <= gain_ff + 5'h01;
							end else if (cfgA_ff[`A_AGC_UPDN]) begin
								// Tracking mode keeps following after settling
								if (gainDownReq[ch] && gain_ff != 5'h00) gain_ff <= gain_ff - 5'h01;
								else if (gainUpReq[ch] && gain_ff != `GAIN_MAX) gain_ff <= gain_ff + 5'h01;
							end else if (gainDownReq[ch] && gain_ff != 5'h00) begin
								gain_ff <= gain_ff - 5'h01;
							end
						end
					end
				end
			end
			always @* begin
				gainSetting[ch*5 +: 5] = gain_ff;
				agcActive[ch] = run_ff;
			end
		end
	endgenerate
	// ****************************************
	// Analog configuration outputs
	// ****************************************
	// Registered so the analog trims change cleanly
	always @(posedge mclk) begin
		if (rst) begin
			chanPowerOn <= 3'b000;
			detTolerance <= 2'b00;
			startGainRed <= 4'h0;
			damperOn <= 1'b0;
			damperShunt <= 2'b00;
			envRate <= 3'b000;
			slicerTime <= 3'b000;
			slicerSymm <= 1'b0;
			slicerThr40 <= 1'b0;
			slicerAbs <= 1'b0;
			slicerAbsLow <= 1'b0;
		end else if (clkEn) begin
			chanPowerOn <= cfgA_ff[2:0];
			detTolerance <= tolEff_ff;
			startGainRed <= gredEff_ff;
			damperOn <= cfgA_ff[`A_DAMP_EN];
			damperShunt <= cfgD_ff[`D_DAMP_HI:`D_DAMP_LO];
			envRate <= cfgC_ff[`C_ENV_HI:`C_ENV_LO];
			slicerTime <= cfgC_ff[`C_SLC_HI:`C_SLC_LO];
			slicerSymm <= cfgC_ff[`C_SYMM];
			slicerThr40 <= cfgC_ff[`C_THR_40];
			slicerAbs <= cfgA_ff[`A_ABS_THR];
			slicerAbsLow <= cfgB_ff[`B_ABS_LOW];
		end
	end
endmodule // lf_wakeup_front_end_control

// ===== lf_front_end_regs.vh
`ifndef LF_FRONT_END_REGS_VH
`define LF_FRONT_END_REGS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFF_CFG_A 8'h04
`define OFF_CFG_B 8'h08
`define OFF_CFG_C 8'h0c
`define OFF_CFG_D 8'h10
`define OFF_CTRL 8'h14
`define OFF_STRENGTH_1 8'h28
`define OFF_STRENGTH_2 8'h2c
`define OFF_STRENGTH_3 8'h30
`define OFF_STATUS 8'h34
// ****************************************
// Field positions
// ****************************************
`define A_ABS_THR 7
`define A_AGC_UPDN 5
`define A_DAMP_EN 4
`define A_TIME_LIM 3
`define A_CH_EN_LO 0
`define B_ABS_LOW 7
`define B_TOL_HI 1
`define B_TOL_LO 0
`define C_THR_40 7
`define C_SYMM 6
`define C_SLC_HI 5
`define C_SLC_LO 3
`define C_ENV_HI 2
`define C_ENV_LO 0
`define D_DAMP_HI 5
`define D_DAMP_LO 4
`define D_GRED_HI 3
`define D_GRED_LO 0
`define CTRL_CLR_WAKE 0
`define CTRL_STR_RESTART 1
// ****************************************
// Reset values
// ****************************************
`define RST_CFG_A 8'h07
`define RST_CFG_B 8'h00
`define RST_CFG_C 8'h00
`define RST_CFG_D 8'h00
// ****************************************
// Timing
// ****************************************
`define AGC_SETTLE_PERIODS 35
`define SLOT_US 256
`define SLOT_RTC_TICKS 9
`define MISS_HALF_SYMBOLS 3
`define GAIN_MAX 5'h1f
`endif

// ===== lf_front_end_monitor.sv
`timescale 1ns/100ps
`include "lf_front_end_regs.vh"
// ****************************************
// Port checker of the front end control
// ****************************************
module lf_front_end_monitor (
	input wire mclk,
	input wire rst,
	input wire clkEn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire [2:0] carrierRaw,
	input wire halfSymTick,
	input wire [2:0] chanPowerOn,
	input wire [2:0] agcActive,
	input wire [14:0] gainSetting,
	input wire [1:0] detTolerance,
	input wire [3:0] startGainRed,
	input wire listenMode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	reg [7:0] awQ_ff; // Address of the last write taken
	reg [7:0] wQ_ff; // Low data byte of the last write taken
	reg [1:0] missCnt_ff; // Half symbols without carrier on channel 0, saturating
	wire [7:0] awAl = {awQ_ff[7:2], 2'b00}; // Word address as the design decodes it
	wire awRo = awAl >= `OFF_STRENGTH_1 && awAl <= `OFF_STATUS; // Read-only window
	wire awMap = awRo || (awAl >= `OFF_CFG_A && awAl <= `OFF_CTRL); // Any decoded place
	// Latch each channel at its own handshake, since they may be taken apart
	always @(posedge mclk) begin
		if (s_axi_awvalid && s_axi_awready) awQ_ff <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wQ_ff <= s_axi_wdata[7:0];
		// A carrier restarts the gap count
		if (rst || carrierRaw[0]) missCnt_ff <= 2'd0;
		// Ticks while the block is frozen are not seen by it, so they do not count
		else if (clkEn && halfSymTick && missCnt_ff != 2'd3) missCnt_ff <= missCnt_ff + 2'd1;
	end
	property p_tol_legal; detTolerance != 2'b11; endproperty
	a_tol_legal: assert property (p_tol_legal)
		else $error("reserved tolerance code driven");
	property p_gred_legal; startGainRed != 4'h1 && startGainRed[3:1] != 3'h1; endproperty
	a_gred_legal: assert property (p_gred_legal)
		else $error("non-applicable gain reduction driven");
	property p_chan_off; !chanPowerOn[0] [*2] |-> !agcActive[0]; endproperty
	a_chan_off: assert property (p_chan_off)
		else $error("disabled channel runs gain control");
	property p_wake_listen;
		$rose(s_axi_bvalid) && s_axi_bresp == 2'b00 && awAl == `OFF_CTRL && wQ_ff[0] |-> ##[0:3] listenMode;
	endproperty
	a_wake_listen: assert property (p_wake_listen)
		else $error("wake clear did not return to listening");
	property p_cmd_clear;
		$rose(s_axi_bvalid) && awAl == `OFF_CTRL && |wQ_ff[1:0] && carrierRaw == 3'b000 |-> ##[0:3] gainSetting == 15'h0;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear)
		else $error("strength not cleared by command");
	// Allow up to one more half symbol for the phase of the gap count
	property p_miss_reset; missCnt_ff == 2'd3 |-> ##[0:20] gainSetting[4:0] == 5'h0; endproperty
	a_miss_reset: assert property (p_miss_reset)
		else $error("gain kept after carrier gap");
	property p_ro_slverr; $rose(s_axi_bvalid) && awRo |-> s_axi_bresp == 2'b10; endproperty
	a_ro_slverr: assert property (p_ro_slverr)
		else $error("write to strength field not refused");
	property p_unmapped; $rose(s_axi_bvalid) && !awMap |-> s_axi_bresp == 2'b11; endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped write not decode error");
endmodule // lf_front_end_monitor

// ===== lf_resonator_model.sv
`timescale 1ns/100ps
// ****************************************
// Three antenna channels behind the analog amplifiers
// ****************************************
module lf_resonator_model (
	input wire mclk,
	input wire [2:0] carrierOn, // Field present per antenna
	input wire [4:0] fieldLevel, // Gain code at which the field is matched
	input wire [14:0] gainSetting,
	output logic carrierTick,
	output logic halfSymTick,
	output logic rtcTick,
	output logic [2:0] carrierRaw,
	output logic [2:0] gainDownReq,
	output logic [2:0] gainUpReq,
	output logic wakeInternal
);
	logic [3:0] divCnt = 4'h0; // Shared divider; time bases are scaled down to keep runs short
	always @(posedge mclk) divCnt <= divCnt + 4'h1;
	assign carrierTick = divCnt[1:0] == 2'b11;
	assign rtcTick = divCnt[2:0] == 3'b111;
	assign halfSymTick = divCnt == 4'hf;
	// Field bursts last far longer than any slicer settling time
	assign carrierRaw = carrierOn;
	assign wakeInternal = |carrierOn;
	// Amplifier asks for a step toward the gain that matches the field
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			gainDownReq[i] = carrierOn[i] && gainSetting[5*i +: 5] > fieldLevel;
			gainUpReq[i] = carrierOn[i] && gainSetting[5*i +: 5] < fieldLevel;
		end
	end
endmodule // lf_resonator_model

// ===== lf_wakeup_front_end_control_tb.sv
`timescale 1ns/100ps
`include "lf_front_end_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module lf_wakeup_front_end_control_tb;
	logic mclk = 1'b0, rst = 1'b1, clkEn = 1'b1; // Clock, reset held at start
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1; // Only lane 0 carries data
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, detTolerance, selChannel, damperShunt;
	wire [31:0] s_axi_rdata;
	wire rtcTick, carrierTick, halfSymTick, wakeInternal, selValid, damperOn;
	wire slicerSymm, slicerThr40, slicerAbs, slicerAbsLow, listenMode;
	wire [2:0] carrierRaw, gainDownReq, gainUpReq, chanPowerOn, agcActive, envRate, slicerTime;
	wire [14:0] gainSetting;
	wire [3:0] startGainRed;
	logic [2:0] carrierOn = 3'b000; // Antennas seeing a field
	logic [4:0] fieldLevel = 5'h0c; // Matched gain code
	int mismatches = 0, n_checks = 0;
	int mreg[4]; // Expected config registers A to D, as written
	logic [1:0] eTol = 2'b00; // Tolerance code in force
	logic [3:0] eGred = 4'h0; // Gain reduction code in force, LSB ignored
	logic [1:0] resp; // Last response code
	logic [31:0] rd; // Last read data
	always #2 mclk = ~mclk;
	lf_wakeup_front_end_control i_lf_wakeup_front_end_control (.*);
	lf_resonator_model i_lf_resonator_model (.*);
	// ****************************************
	// Bus tasks and the closing report
	// ****************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		$display("ERROR %0t: bus timeout", $time);
		test_done();
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 64);
		if (n >= 64) hang();
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		int n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 64);
		if (n >= 64) hang();
		rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
	// Config write plus model update; registers read back as written,
	// while reserved codes leave the setting in force alone
	task automatic mwr(input int i, input logic [7:0] d);
		wr(8'h04 + 8'(i * 4), d);
		mreg[i] = d;
		if (i == 1 && d[1:0] != 2'b11) eTol = d[1:0];
		if (i == 3 && (d[3:0] == 4'h0 || d[3:2] != 2'b00)) eGred = {d[3:1], 1'b0};
	endtask
	task automatic chk_cfg();
		logic [7:0] a, b, c, e;
		a = 8'(mreg[0]);
		b = 8'(mreg[1]);
		c = 8'(mreg[2]);
		e = 8'(mreg[3]);
		repeat (2) @(posedge mclk);
		`CHK(chanPowerOn, a[2:0])
		`CHK(damperOn, a[4])
		`CHK(slicerAbs, a[7])
		`CHK(slicerAbsLow, b[7])
		`CHK(detTolerance, eTol)
		`CHK(envRate, c[2:0])
		`CHK(slicerTime, c[5:3])
		`CHK(slicerSymm, c[6])
		`CHK(slicerThr40, c[7])
		`CHK(startGainRed, eGred)
		`CHK(damperShunt, e[5:4])
		for (int i = 0; i < 4; i++) begin
			rdr(8'h04 + 8'(i * 4));
			`CHK(rd, 32'(mreg[i]))
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h8c274d7f));
		mreg = '{32'h07, 32'h00, 32'h00, 32'h00};
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		`CHK(listenMode, 1'b1)
		chk_cfg();
		$display("test reset done");
		// Every code of the enable, tolerance, slicer, envelope and gain reduction fields, other bits random
		for (int i = 0; i < 16; i++) begin
			logic [7:0] d;
			d = 8'($urandom);
			mwr(0, {d[7:3], i[2:0]});
			mwr(1, {d[7:2], i[1:0]});
			mwr(2, {d[7:6], ~i[2:0], i[2:0]});
			mwr(3, {d[7:4], i[3:0]});
			chk_cfg();
		end
		$display("test config done");
		wr(`OFF_STRENGTH_1, 8'h1f);
		`CHK(resp, 2'b10)
		wr(8'h3c, 8'h00);
		`CHK(resp, 2'b11)
		$display("test refusal done");
		// Down-only, no time limit, full starting gain
		mwr(0, 8'h07);
		mwr(3, 8'h00);
		carrierOn <= 3'b111;
		repeat (150) @(posedge mclk);
		`CHK(gainSetting, {3{5'h0c}})
		rdr(`OFF_STRENGTH_2);
		`CHK(rd, 32'h0c)
		fieldLevel <= 5'h18;
		repeat (150) @(posedge mclk);
		`CHK(gainSetting, {3{5'h0c}})
		mwr(0, 8'h27);
		repeat (150) @(posedge mclk);
		`CHK(gainSetting, {3{5'h18}})
		wr(`OFF_CTRL, 8'h02);
		repeat (150) @(posedge mclk);
		`CHK(gainSetting, {3{5'h18}})
		rdr(`OFF_STATUS);
		`CHK(rd[7:6], 2'b11)
		carrierOn <= 3'b000;
		repeat (80) @(posedge mclk);
		`CHK(gainSetting, 15'h0)
		wr(`OFF_CTRL, 8'h01);
		repeat (3) @(posedge mclk);
		`CHK(listenMode, 1'b1)
		mwr(0, 8'h06);
		carrierOn <= 3'b111;
		repeat (150) @(posedge mclk);
		`CHK(agcActive[0], 1'b0)
		`CHK(gainSetting, {5'h18, 5'h18, 5'h00})
		$display("test gain done");
		// Clock enable low freezes the gap count and the gains
		clkEn <= 1'b0;
		carrierOn <= 3'b000;
		repeat (60) @(posedge mclk);
		`CHK(gainSetting, {5'h18, 5'h18, 5'h00})
		clkEn <= 1'b1;
		repeat (60) @(posedge mclk);
		`CHK(gainSetting, 15'h0)
		$display("test freeze done");
		// Time limit: slot long closed, so gain stays at its start value
		mwr(0, 8'h2f);
		carrierOn <= 3'b111;
		repeat (150) @(posedge mclk);
		`CHK(gainSetting, {3{5'h1f}})
		// Wake clear reopens the slot; the gain settles inside it
		wr(`OFF_CTRL, 8'h01);
		repeat (150) @(posedge mclk);
		`CHK(gainSetting, {3{5'h18}})
		$display("test time limit done");
		test_done();
	end
endmodule // lf_wakeup_front_end_control_tb
bind lf_wakeup_front_end_control lf_front_end_monitor i_lf_front_end_monitor (.*);
